//--- verilog/irq_bank_pkg.sv
// Package with register map, field layout and reset values of the bank.
// Function
// - Four read/write timer interrupt enables in bits 0-3, reset to 0.
// - Key group enable in bit 0, reset 0, upper bits read zero.
// - One hertz tick enable in bit 0, reset 0, upper bits zero.
// - Converter enable in bit 0, reset 0, upper bits read zero.
// - Four timer pending flags; write 1 clears, write 0 keeps, reset 0.
// - Key group pending flag bit 0; write 1 clears; upper bits zero.
// - One hertz pending flag bit 0; write 1 clears; upper bits zero.
// - Converter pending flag bit 0; write 1 clears; upper bits zero.
package irq_bank_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_TIMER_EN  = 16'hFFE2;
    localparam logic [15:0] IDX_KEY_EN    = 16'hFFE4;
    localparam logic [15:0] IDX_TICK_EN   = 16'hFFE6;
    localparam logic [15:0] IDX_CONV_EN   = 16'hFFE7;
    localparam logic [15:0] IDX_TIMER_PND = 16'hFFF2;
    localparam logic [15:0] IDX_KEY_PND   = 16'hFFF4;
    localparam logic [15:0] IDX_TICK_PND  = 16'hFFF6;
    localparam logic [15:0] IDX_CONV_PND  = 16'hFFF7;
    localparam int          ADDR_W        = 18;
    // Bit positions of the sources inside the seven-bit source vector.
    localparam int          SRC_N         = 7;
    localparam int          POS_TIMER     = 0;
    localparam int          POS_KEY       = 4;
    localparam int          POS_TICK      = 5;
    localparam int          POS_CONV      = 6;
    // Reset values.
    localparam logic [6:0]  EN_RST        = 7'h00;
    localparam logic [6:0]  PND_RST       = 7'h00;
    // AXI response codes.
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [3:0] {
        SEL_NONE, SEL_TIMER_EN, SEL_KEY_EN, SEL_TICK_EN, SEL_CONV_EN,
        SEL_TIMER_PND, SEL_KEY_PND, SEL_TICK_PND, SEL_CONV_PND
    } reg_sel_t;
endpackage

//--- verilog/sticky_flags.sv
// Sticky event flags with write-one clear in which a set wins.
module sticky_flags #(
    parameter int N = 7
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [N-1:0] set_pulse,
    input  wire logic [N-1:0] clr_pulse,
    output logic      [N-1:0] flags
);
    import irq_bank_pkg::*;

    typedef struct packed {
        logic [N-1:0] flag;
    } flags_state_t;

    flags_state_t s_q;
    flags_state_t s_d;

    // A clear drops only the flags whose event is not arriving now.
    always_comb begin
        s_d      = s_q;
        s_d.flag = (s_q.flag & ~clr_pulse) | set_pulse;
    end

    // Flags come up cleared after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q.flag <= PND_RST[N-1:0];
        end else begin
            s_q <= s_d;
        end
    end

    assign flags = s_q.flag;
endmodule

//--- verilog/axil_write_join.sv
// Catches AXI4-Lite write address and write data in either order.
module axil_write_join #(
    parameter int AW = 18
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    input  wire logic          consume,
    output logic               both_have,
    output logic [AW-1:0]      addr,
    output logic [31:0]        data,
    output logic [3:0]         strb
);
    typedef struct packed {
        logic          aw_have;
        logic          w_have;
        logic [AW-1:0] addr;
        logic [31:0]   data;
        logic [3:0]    strb;
    } join_state_t;

    join_state_t s_q;
    join_state_t s_d;

    // Each channel is held off once its half is caught, so the slave never
    // needs more than one word of storage per channel.
    assign awready   = !s_q.aw_have;
    assign wready    = !s_q.w_have;
    assign both_have = s_q.aw_have && s_q.w_have;
    assign addr      = s_q.addr;
    assign data      = s_q.data;
    assign strb      = s_q.strb;

    // Capture each half on its handshake and drop both when consumed.
    always_comb begin
        s_d = s_q;
        if (consume) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
        end
        if (awvalid && awready) begin
            s_d.aw_have = 1'b1;
            s_d.addr    = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_have = 1'b1;
            s_d.data   = wdata;
            s_d.strb   = wstrb;
        end
    end

    // Nothing is held after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

//--- verilog/irq_mask_flag_bank.sv
// Interrupt enable and pending flag bank behind an AXI4-Lite slave.
module irq_mask_flag_bank (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [3:0]                  timer_evt,
    input  wire logic                        key_input_group_evt,
    input  wire logic                        one_hz_evt,
    input  wire logic                        conv_evt,
    output logic                             irq
);
    import irq_bank_pkg::*;

    typedef struct packed {
        logic [SRC_N-1:0] en;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic             irq;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;

    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_both;
    logic              wr_go;
    logic              rd_go;
    reg_sel_t          wr_sel;
    reg_sel_t          rd_sel;
    logic [SRC_N-1:0]  evt;
    logic [SRC_N-1:0]  clr;
    logic [SRC_N-1:0]  pend;

    // Maps a byte address onto the register it selects; the low two
    // address bits must be zero because each register owns a word.
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        reg_sel_t r;
        r = SEL_NONE;
        if (a[1:0] == 2'h0) begin
            unique case (a[ADDR_W-1:2])
                IDX_TIMER_EN:  r = SEL_TIMER_EN;
                IDX_KEY_EN:    r = SEL_KEY_EN;
                IDX_TICK_EN:   r = SEL_TICK_EN;
                IDX_CONV_EN:   r = SEL_CONV_EN;
                IDX_TIMER_PND: r = SEL_TIMER_PND;
                IDX_KEY_PND:   r = SEL_KEY_PND;
                IDX_TICK_PND:  r = SEL_TICK_PND;
                IDX_CONV_PND:  r = SEL_CONV_PND;
                default:       r = SEL_NONE;
            endcase
        end
        return r;
    endfunction

    axil_write_join #(
        .AW (ADDR_W)
    ) u_wjoin (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .awaddr    (s_axi_awaddr),
        .awvalid   (s_axi_awvalid),
        .awready   (s_axi_awready),
        .wdata     (s_axi_wdata),
        .wstrb     (s_axi_wstrb),
        .wvalid    (s_axi_wvalid),
        .wready    (s_axi_wready),
        .consume   (wr_go),
        .both_have (wr_both),
        .addr      (wr_addr),
        .data      (wr_data),
        .strb      (wr_strb)
    );

    // A write is carried out once both halves are in and the previous
    // response has left, so only one write is ever under way.
    assign wr_go  = wr_both && !s_q.bvalid;
    assign wr_sel = decode(wr_addr);
    assign rd_go  = s_axi_arvalid && s_axi_arready;
    assign rd_sel = decode(s_axi_araddr);

    // Event sources gathered into one vector; flags set without the mask.
    assign evt = {conv_evt, one_hz_evt, key_input_group_evt, timer_evt};

    // Write-one clear pulses; only byte lane 0 carries register bits.
    always_comb begin
        clr = '0;
        if (wr_go && wr_strb[0]) begin
            unique case (wr_sel)
                SEL_TIMER_PND: clr[POS_TIMER +: 4] = wr_data[3:0];
                SEL_KEY_PND:   clr[POS_KEY]  = wr_data[0];
                SEL_TICK_PND:  clr[POS_TICK] = wr_data[0];
                SEL_CONV_PND:  clr[POS_CONV] = wr_data[0];
                default:       clr = '0;
            endcase
        end
    end

    sticky_flags #(
        .N (SRC_N)
    ) u_flags (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .set_pulse (evt),
        .clr_pulse (clr),
        .flags     (pend)
    );

    // Read channel accepts a new address only after the data has gone.
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign irq           = s_q.irq;

    // Register writes, read data capture and the interrupt request.
    always_comb begin
        s_d = s_q;
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wr_strb[0]) begin
                unique case (wr_sel)
                    SEL_TIMER_EN: s_d.en[POS_TIMER +: 4] = wr_data[3:0];
                    SEL_KEY_EN:   s_d.en[POS_KEY]  = wr_data[0];
                    SEL_TICK_EN:  s_d.en[POS_TICK] = wr_data[0];
                    SEL_CONV_EN:  s_d.en[POS_CONV] = wr_data[0];
                    default:      s_d.en = s_q.en;
                endcase
            end
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            // Narrow registers leave bits 31:1 at zero.
            unique case (rd_sel)
                SEL_TIMER_EN:  s_d.rdata[3:0] = s_q.en[POS_TIMER +: 4];
                SEL_KEY_EN:    s_d.rdata[0] = s_q.en[POS_KEY];
                SEL_TICK_EN:   s_d.rdata[0] = s_q.en[POS_TICK];
                SEL_CONV_EN:   s_d.rdata[0] = s_q.en[POS_CONV];
                SEL_TIMER_PND: s_d.rdata[3:0] = pend[POS_TIMER +: 4];
                SEL_KEY_PND:   s_d.rdata[0] = pend[POS_KEY];
                SEL_TICK_PND:  s_d.rdata[0] = pend[POS_TICK];
                SEL_CONV_PND:  s_d.rdata[0] = pend[POS_CONV];
                default:       s_d.rdata = 32'h0000_0000;
            endcase
        end
        // Registered so the request is glitch free; it lags the flags by
        // one cycle, which the processor never notices.
        s_d.irq = |(pend & s_q.en);
    end

    // All enables masked and no answer pending after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q        <= '0;
            s_q.en     <= EN_RST;
            s_q.bresp  <= RESP_OKAY;
            s_q.rresp  <= RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    // Checks of the bank's behaviour, all on the one clock domain.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_timer_en_write: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_TIMER_EN
        |=> s_q.en[3:0] == $past(wr_data[3:0]))
        else $error("timer enables did not take the written value");

    a_key_en_write: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_KEY_EN
        |=> s_q.en[POS_KEY] == $past(wr_data[0]))
        else $error("key group enable did not take the written bit");

    a_tick_en_write: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_TICK_EN
        |=> s_q.en[POS_TICK] == $past(wr_data[0]))
        else $error("one hertz enable did not take the written bit");

    a_narrow_read_zero: assert property (
        rd_go && rd_sel inside {SEL_KEY_EN, SEL_TICK_EN, SEL_CONV_EN,
            SEL_KEY_PND, SEL_TICK_PND, SEL_CONV_PND}
        |=> s_axi_rvalid && s_axi_rdata[31:1] == 31'h0000_0000)
        else $error("narrow register read returned nonzero upper bits");

    a_timer_w1c: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_TIMER_PND
        |=> (pend[3:0] & $past(wr_data[3:0] & ~timer_evt)) == 4'h0)
        else $error("timer flag survived a write of one");

    a_key_zero_keeps: assert property (
        pend[POS_KEY] && !(wr_go && wr_strb[0] && wr_sel == SEL_KEY_PND
        && wr_data[0]) |=> pend[POS_KEY])
        else $error("key group flag lost without a write of one");

    a_tick_w1c: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_TICK_PND && wr_data[0]
        && !one_hz_evt |=> !pend[POS_TICK])
        else $error("one hertz flag not cleared by a write of one");

    a_conv_w1c: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_CONV_PND && wr_data[0]
        && !conv_evt |=> !pend[POS_CONV] ##1 !irq || pend[POS_CONV])
        else $error("converter flag not cleared by a write of one");

    a_irq_follows: assert property (
        |(pend & s_q.en) |=> irq)
        else $error("request missing while an enabled flag is set");

    a_irq_drops: assert property (
        !(|(pend & s_q.en)) |=> !irq)
        else $error("request present with no enabled flag set");

    a_set_wins: assert property (
        |evt |=> (pend & $past(evt)) == $past(evt))
        else $error("event did not leave its flag set");

    // Clears spare every flag that is written with zero.
    a_timer_zero_keeps: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_TIMER_PND
        |=> (pend[3:0] | ~$past(pend[3:0] & ~wr_data[3:0])) == 4'hF)
        else $error("timer flag lost on a write of zero");

    a_key_w1c: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_KEY_PND && wr_data[0]
        && !key_input_group_evt |=> !pend[POS_KEY])
        else $error("key group flag not cleared by a write of one");

    a_tick_zero_keeps: assert property (
        pend[POS_TICK] && !(wr_go && wr_strb[0] && wr_sel == SEL_TICK_PND
        && wr_data[0]) |=> pend[POS_TICK])
        else $error("one hertz flag lost without a write of one");

    a_conv_zero_keeps: assert property (
        pend[POS_CONV] && !(wr_go && wr_strb[0] && wr_sel == SEL_CONV_PND
        && wr_data[0]) |=> pend[POS_CONV])
        else $error("converter flag lost without a write of one");

    a_conv_en_write: assert property (
        wr_go && wr_strb[0] && wr_sel == SEL_CONV_EN
        |=> s_q.en[POS_CONV] == $past(wr_data[0]))
        else $error("converter enable did not take the written bit");

    a_key_pend_read: assert property (
        rd_go && rd_sel == SEL_KEY_PND
        |=> s_axi_rdata[0] == $past(pend[POS_KEY]))
        else $error("key group flag read back wrong");

    a_timer_read_upper: assert property (
        rd_go && rd_sel inside {SEL_TIMER_EN, SEL_TIMER_PND}
        |=> s_axi_rdata[31:4] == 28'h000_0000)
        else $error("timer register read returned nonzero upper bits");

    // A write without lane 0 must leave every enable as it was.
    a_no_strobe_keeps: assert property (
        wr_go && !wr_strb[0]
        |=> s_q.en == $past(s_q.en))
        else $error("enables changed by a write without lane 0");

    a_bad_wr_err: assert property (
        wr_go && wr_sel == SEL_NONE
        |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not answered with an error");

    a_bad_rd_err: assert property (
        rd_go && rd_sel == SEL_NONE |=> s_axi_rvalid
        && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not answered with an error");

    a_wr_answer: assert property (
        wr_go
        |=> s_axi_bvalid)
        else $error("write response missing after execution");

    a_rd_answer: assert property (
        rd_go
        |=> s_axi_rvalid)
        else $error("read data missing after the address was taken");

    // Answers stand until taken, and held halves keep the bus refused.
    a_bvalid_holds: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");

    a_rvalid_holds: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before it was taken");

    a_halves_held: assert property (
        wr_both
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while a write is held");

    a_read_held: assert property (
        s_axi_rvalid
        |-> !s_axi_arready)
        else $error("read address ready while read data stands");

    // Main scenarios worth seeing at least once.
    c_no_strobe: cover property (wr_go && !wr_strb[0]);
    c_enable_write: cover property (
        wr_go && wr_sel == SEL_TIMER_EN);
    c_irq_rise: cover property (!irq ##1 irq);
    c_set_clear_clash: cover property (|(evt & clr));
    c_bad_address: cover property (rd_go && rd_sel == SEL_NONE);
endmodule

//--- tb/irq_evt_source.sv
// Behavioural interrupt sources that pulse each event line for one cycle.
module irq_evt_source (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [6:0] fire,
    output logic      [3:0] timer_evt,
    output logic            key_input_group_evt,
    output logic            one_hz_evt,
    output logic            conv_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] pulse_q;
    // A request becomes a one-cycle pulse one clock later, as from a timer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_q <= 7'h00;
        end else begin
            pulse_q <= fire;
        end
    end
    // Split the pulse vector onto the separate source lines.
    assign timer_evt           = pulse_q[3:0];
    assign key_input_group_evt = pulse_q[4];
    assign one_hz_evt          = pulse_q[5];
    assign conv_evt            = pulse_q[6];
endmodule

//--- tb/irq_mask_flag_bank_bench.sv
// Self-checking bench for the interrupt enable and pending flag bank.
module irq_mask_flag_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_bank_pkg::*;
    logic        aclk, aresetn, irq, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        key_input_group_evt, one_hz_evt, conv_evt;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb, timer_evt;
    logic [6:0]  fire;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    int          n_fail, compares, cycles;
    // Byte addresses, readable bits and source bits of each group.
    logic [17:0] en_a [4] = '{{IDX_TIMER_EN, 2'h0}, {IDX_KEY_EN, 2'h0},
                              {IDX_TICK_EN, 2'h0}, {IDX_CONV_EN, 2'h0}};
    logic [17:0] pn_a [4] = '{{IDX_TIMER_PND, 2'h0}, {IDX_KEY_PND, 2'h0},
                              {IDX_TICK_PND, 2'h0}, {IDX_CONV_PND, 2'h0}};
    logic [31:0] fm [4] = '{32'hF, 32'h1, 32'h1, 32'h1};
    logic [6:0]  src [4] = '{7'h0F, 7'h10, 7'h20, 7'h40};

    irq_mask_flag_bank u_irq_mask_flag_bank (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .timer_evt, .key_input_group_evt,
        .one_hz_evt, .conv_evt, .irq
    );
    irq_evt_source u_irq_evt_source (
        .aclk, .aresetn, .fire, .timer_evt, .key_input_group_evt,
        .one_hz_evt, .conv_evt
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Both halves go out together; a fire request rides the same edge so
    // that a source pulse can meet the write's execute edge.
    task automatic wr(input logic [17:0] a, input logic [31:0] v,
                      input logic [6:0] f);
        logic ta, tw, ha, hw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fire <= f;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            fire <= 7'h00;
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            ta = ta | ha;
            tw = tw | hw;
        end
        ha = 1'b0;
        while (!ha) begin
            @(negedge aclk);
            ha = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] a);
        logic h;
        h = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!h) begin
            @(negedge aclk);
            h = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        h = 1'b0;
        while (!h) begin
            @(negedge aclk);
            h = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
    endtask
    // The request lags the flag by one register, hence the settling wait.
    task automatic pulse(input logic [6:0] f);
        @(posedge aclk);
        fire <= f;
        @(posedge aclk);
        fire <= 7'h00;
        repeat (3) @(negedge aclk);
    endtask
    task automatic wr_irq(input logic [17:0] a, input logic [31:0] v,
                          input logic e);
        wr(a, v, 7'h00);
        repeat (2) @(negedge aclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // Every location reads zero after reset; the enable reads also check for an OKAY response.
    task automatic t_reset;
        for (int k = 0; k < 4; k++) begin
            rd(en_a[k]);
            chk(d, 32'h0);
            chk({30'h0, r}, {30'h0, RESP_OKAY});
            rd(pn_a[k]);
            chk(d, 32'h0);
        end
    endtask
    // All-ones writes keep only the live bits; zero writes back.
    task automatic t_enable;
        for (int k = 0; k < 4; k++) begin
            wr(en_a[k], 32'hFFFFFFFF, 7'h00);
            rd(en_a[k]);
            chk(d, fm[k]);
            wr(en_a[k], 32'h0, 7'h00);
            rd(en_a[k]);
            chk(d, 32'h0);
        end
    endtask
    // Masked events still latch; a zero keeps a flag, a one clears it.
    task automatic t_flags;
        pulse(7'h7F);
        chk({31'h0, irq}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(pn_a[k], 32'h0, 7'h00);
            rd(pn_a[k]);
            chk(d, fm[k]);
            wr(pn_a[k], 32'h5, 7'h00);
            rd(pn_a[k]);
            chk(d, fm[k] & 32'hA);
            wr(pn_a[k], 32'hF, 7'h00);
            rd(pn_a[k]);
            chk(d, 32'h0);
        end
    endtask
    // The request follows each flag and enable pair, then a crossed pair.
    task automatic t_irq;
        for (int k = 0; k < 4; k++) begin
            pulse(src[k]);
            wr_irq(en_a[k], fm[k], 1'b1);
            wr_irq(en_a[k], 32'h0, 1'b0);
            wr_irq(en_a[k], fm[k], 1'b1);
            wr_irq(pn_a[k], fm[k], 1'b0);
            wr_irq(en_a[k], 32'h0, 1'b0);
        end
        wr_irq(en_a[0], 32'h4, 1'b0);
        pulse(7'h02);
        chk({31'h0, irq}, 32'h0);
        pulse(7'h04);
        chk({31'h0, irq}, 32'h1);
        wr_irq(pn_a[0], 32'hF, 1'b0);
        wr_irq(en_a[0], 32'h0, 1'b0);
    endtask
    // A source pulse on the execute edge of a clearing write wins.
    task automatic t_setwin;
        pulse(7'h01);
        wr(pn_a[0], 32'h1, 7'h01);
        rd(pn_a[0]);
        chk(d, 32'h1);
        wr(pn_a[0], 32'h1, 7'h02);
        rd(pn_a[0]);
        chk(d, 32'h2);
        wr(pn_a[0], 32'hF, 7'h00);
    endtask
    // Holes and misaligned addresses answer an error and change nothing.
    task automatic t_bad;
        wr(18'h3FF8C, 32'hF, 7'h00);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rd(18'h3FF8C);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(en_a[0] | 18'h1, 32'hF, 7'h00);
        rd(en_a[0]);
        chk(d, 32'h0);
        s_axi_wstrb <= 4'hE;
        wr(en_a[0], 32'hF, 7'h00);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        s_axi_wstrb <= 4'hF;
        rd(en_a[0]);
        chk(d, 32'h0);
    endtask

    // Free-running clock at 50 MHz.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Cut a hang short well beyond the few hundred cycles the tests need.
    initial begin
        cycles = 0;
        forever begin
            @(posedge aclk);
            cycles++;
            if (cycles == 20000) begin
                n_fail++;
                report_and_stop();
            end
        end
    end
    // Main sequence.
    initial begin
        n_fail = 0;
        compares = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 68'h0;
        s_axi_wstrb = 4'hF;
        fire = 7'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_enable();
        t_flags();
        t_irq();
        t_setwin();
        t_bad();
        report_and_stop();
    end
endmodule
